// ### rtl/pts_defines.svh
// constants for the processor trap sequencer
`ifndef PTS_DEFINES_SVH
`define PTS_DEFINES_SVH
`define PTS_VEC_BUS_ERR 16'h0004
`define PTS_VEC_RESERVED 16'h0008
`define PTS_VEC_TRACE 16'h000C
`define PTS_VEC_IOT 16'h0010
`define PTS_VEC_POWER 16'h0014
`define PTS_VEC_EMT 16'h0018
`define PTS_VEC_TRAP 16'h001C
`define PTS_VEC_PARITY 16'h0072
`define PTS_VEC_MMU 16'h00A8
`define PTS_VEC_FPU 16'h00A4
`define PTS_CLK_NS 100
`define PTS_PF_RUN_NS 2000000
`define PTS_PF_RUN_CYC ((`PTS_PF_RUN_NS + `PTS_CLK_NS - 1) / `PTS_CLK_NS)
`define PTS_TIMEOUT_CYC 100
`define PTS_NSRC 12
`endif

// ### rtl/pts_pkg.sv
// types for the processor trap sequencer
`default_nettype none
package pts_pkg;
  typedef enum logic [2:0] {
    PTS_IDLE = 3'b000,
    PTS_PUSH_PSW = 3'b001,
    PTS_PUSH_PC = 3'b010,
    PTS_READ_PC = 3'b011,
    PTS_READ_PSW = 3'b100,
    PTS_DONE = 3'b101
  } pts_state_t;
endpackage
`default_nettype wire

// ### rtl/pts_trap_sequencer.sv
// trap sequencer: detects trap causes, pushes pc and status word, loads vectors
// Overview of operation
// - power-fail indication traps through vector 24
// - keep executing at least 2 msec after
// - power restore traps again through vector 24
// - odd-address word access aborts, traps via 4
// - flag time-out when no slave reply
// - bus time-out aborts instruction, traps via 4
// - reserved instruction traps through vector 10
// - push pc and status word, then run
// - other fixed-vector traps also serviced
`include "pts_defines.svh"
`default_nettype none
module pts_trap_sequencer #(
  parameter int PF_RUN_CYC = `PTS_PF_RUN_CYC,
  parameter int TIMEOUT_CYC = `PTS_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // power monitor
  input wire logic power_fail,
  // core bus cycle
  input wire logic bus_master_sync,
  input wire logic bus_slave_sync,
  input wire logic bus_word_access,
  input wire logic bus_addr_lsb,
  // core trap causes, one-cycle pulses
  input wire logic reserved_instr,
  input wire logic stack_error,
  input wire logic parity_error,
  input wire logic mmu_violation,
  input wire logic fpu_exception,
  input wire logic trace_bit,
  input wire logic io_service_trap_instruction,
  input wire logic emulator_trap_instruction,
  input wire logic trap_instruction,
  // core state and memory port
  input wire logic [15:0] cur_pc,
  input wire logic [15:0] cur_processor_status_word,
  input wire logic [15:0] cur_sp,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic mem_req,
  output logic mem_write,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  // results to the core
  output logic abort_instr,
  output logic timeout_flag,
  output logic trap_busy,
  output logic load_state,
  output logic [15:0] new_pc,
  output logic [15:0] new_processor_status_word,
  output logic [15:0] new_sp,
  output logic pf_window
);
  localparam int NS = `PTS_NSRC;
  pts_pkg::pts_state_t state, next_state;
  logic [NS-1:0] pend;
  logic [NS-1:0] grant;
  logic [15:0] vec;
  logic [15:0] sp;
  logic pf_q;
  logic [$clog2(TIMEOUT_CYC+1)-1:0] to_cnt;
  logic [$clog2(PF_RUN_CYC+1)-1:0] pf_cnt;
  // source order is priority order, bit 0 highest
  wire logic odd_err = bus_master_sync & bus_word_access & bus_addr_lsb;
  wire logic to_err = bus_master_sync & ~bus_slave_sync
    & (to_cnt == ($bits(to_cnt))'(TIMEOUT_CYC - 1));
  wire logic pf_edge = power_fail ^ pf_q;
  wire logic [NS-1:0] raise = {trap_instruction, emulator_trap_instruction,
    io_service_trap_instruction, trace_bit, fpu_exception, mmu_violation,
    reserved_instr, parity_error, stack_error, pf_edge, to_err, odd_err};
  localparam logic [15:0] VEC_TAB [NS] = '{`PTS_VEC_BUS_ERR, `PTS_VEC_BUS_ERR,
    `PTS_VEC_POWER, `PTS_VEC_BUS_ERR, `PTS_VEC_PARITY, `PTS_VEC_RESERVED,
    `PTS_VEC_MMU, `PTS_VEC_FPU, `PTS_VEC_TRACE, `PTS_VEC_IOT,
    `PTS_VEC_EMT, `PTS_VEC_TRAP};
  wire logic take = (state == pts_pkg::PTS_IDLE) & (|pend);
  wire logic step = mem_req & mem_ack;
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_pri
      if (g == 0) begin : g_top
        assign grant[g] = pend[g];
      end else begin : g_rest
        assign grant[g] = pend[g] & ~(|pend[g-1:0]);
      end
    end
  endgenerate
  always_comb begin
    vec = 16'h0000;
    for (int i = 0; i < NS; i++) begin
      if (grant[i]) begin
        vec = VEC_TAB[i];
      end
    end
  end
  always_comb begin
    next_state = state;
    unique case (state)
      pts_pkg::PTS_IDLE: if (take) next_state = pts_pkg::PTS_PUSH_PSW;
      pts_pkg::PTS_PUSH_PSW: if (step) next_state = pts_pkg::PTS_PUSH_PC;
      pts_pkg::PTS_PUSH_PC: if (step) next_state = pts_pkg::PTS_READ_PC;
      pts_pkg::PTS_READ_PC: if (step) next_state = pts_pkg::PTS_READ_PSW;
      pts_pkg::PTS_READ_PSW: if (step) next_state = pts_pkg::PTS_DONE;
      pts_pkg::PTS_DONE: next_state = pts_pkg::PTS_IDLE;
      default: next_state = pts_pkg::PTS_IDLE;
    endcase
  end
  // a new cause landing in the cycle its bit is cleared stays pending
  always_ff @(posedge clk) begin
    if (srst) begin
      pend <= '0;
    end else begin
      pend <= (pend & ~(take ? grant : '0)) | raise;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      to_cnt <= '0;
    end else if (bus_master_sync & ~bus_slave_sync & ~to_err) begin
      to_cnt <= to_cnt + 1'b1;
    end else begin
      to_cnt <= '0;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      pf_q <= 1'b0;
      pf_cnt <= '0;
      pf_window <= 1'b0;
    end else begin
      pf_q <= power_fail;
      // the core is never halted by this block during the save window
      if (power_fail & ~pf_q) begin
        pf_cnt <= ($bits(pf_cnt))'(PF_RUN_CYC);
        pf_window <= 1'b1;
      end else if (pf_cnt != '0) begin
        pf_cnt <= pf_cnt - 1'b1;
        pf_window <= (pf_cnt != ($bits(pf_cnt))'(1));
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= pts_pkg::PTS_IDLE;
      abort_instr <= 1'b0;
      timeout_flag <= 1'b0;
      trap_busy <= 1'b0;
      load_state <= 1'b0;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      new_pc <= 16'h0000;
      new_processor_status_word <= 16'h0000;
      new_sp <= 16'h0000;
      sp <= 16'h0000;
    end else begin
      state <= next_state;
      abort_instr <= odd_err | to_err;
      timeout_flag <= to_err;
      trap_busy <= (next_state != pts_pkg::PTS_IDLE);
      load_state <= (state == pts_pkg::PTS_DONE);
      mem_req <= 1'b0;
      unique case (state)
        pts_pkg::PTS_IDLE: if (take) begin
          sp <= cur_sp - 16'h0002;
          mem_req <= 1'b1;
          mem_write <= 1'b1;
          mem_addr <= cur_sp - 16'h0002;
          mem_wdata <= cur_processor_status_word;
          new_pc <= vec;
        end
        pts_pkg::PTS_PUSH_PSW: begin
          mem_req <= ~step;
          if (step) begin
            sp <= sp - 16'h0002;
            mem_req <= 1'b1;
            mem_addr <= sp - 16'h0002;
            mem_wdata <= cur_pc;
          end
        end
        pts_pkg::PTS_PUSH_PC: begin
          mem_req <= 1'b1;
          if (step) begin
            mem_write <= 1'b0;
            mem_addr <= new_pc;
          end
        end
        pts_pkg::PTS_READ_PC: begin
          mem_req <= 1'b1;
          if (step) begin
            mem_addr <= mem_addr + 16'h0002;
            new_pc <= mem_rdata;
          end
        end
        pts_pkg::PTS_READ_PSW: begin
          mem_req <= ~step;
          if (step) begin
            new_processor_status_word <= mem_rdata;
            new_sp <= sp;
          end
        end
        pts_pkg::PTS_DONE: mem_req <= 1'b0;
        default: mem_req <= 1'b0;
      endcase
    end
  end
  a_odd_abort: assert property (@(posedge clk) disable iff (srst)
    odd_err |=> abort_instr) else $error("odd access not aborted");
  a_timeout_abort: assert property (@(posedge clk) disable iff (srst)
    to_err |=> abort_instr && timeout_flag) else $error("time-out missed");
  a_pf_pending: assert property (@(posedge clk) disable iff (srst)
    pf_edge |=> pend[2]) else $error("power event lost");
  a_pf_window: assert property (@(posedge clk) disable iff (srst)
    (power_fail && !pf_q) |=> pf_window [*8]) else $error("save window short");
  a_restore_trap: assert property (@(posedge clk) disable iff (srst)
    (!power_fail && pf_q) |=> pend[2]) else $error("restore trap lost");
  a_reserved_vec: assert property (@(posedge clk) disable iff (srst)
    (take && grant[5]) |=> new_pc == `PTS_VEC_RESERVED) else $error("bad vector");
  a_push_first: assert property (@(posedge clk) disable iff (srst)
    take |=> mem_req && mem_write) else $error("no push after trap");
  a_one_grant: assert property (@(posedge clk) disable iff (srst)
    $onehot0(grant)) else $error("more than one grant");
  a_load_between: assert property (@(posedge clk) disable iff (srst)
    load_state |-> !trap_busy) else $error("next trap began before vector load");
  a_psw_addr: assert property (@(posedge clk) disable iff (srst)
    (state == pts_pkg::PTS_READ_PC && step) |=> mem_addr == $past(mem_addr) + 16'h0002)
    else $error("psw not at vector+2");
  a_bus_trap: assert property (@(posedge clk) disable iff (srst)
    (take && grant[0]) |=> new_pc == `PTS_VEC_BUS_ERR) else $error("bus vector");
  c_power: cover property (@(posedge clk) take && grant[2]);
  c_timeout: cover property (@(posedge clk) to_err);
  c_full_trap: cover property (@(posedge clk) load_state);
endmodule
`default_nettype wire

// ### test/pts_mem_model.sv
// memory partner: answers trap sequencer memory requests after a set latency
`default_nettype none
module pts_mem_model (
  // clock
  input wire logic clk,
  // request side
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic [3:0] lat,
  // answer side
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  logic [15:0] last = 16'h0000;
  initial mem_ack = 1'b0;
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    if (mem_req && !mem_ack && n >= lat) begin
      mem_ack <= 1'b1;
      last <= mem_addr ^ 16'h3C00;
      n = 0;
    end else if (mem_req && !mem_ack) begin
      n = n + 1;
    end
  end
  // stale data is inverted so a late sample never passes for a match
  assign mem_rdata = mem_ack ? last : ~last;
endmodule
`default_nettype wire

// ### test/pts_trap_sequencer_tb.sv
// bench for the trap sequencer
`include "pts_defines.svh"
`default_nettype none
module pts_trap_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TO = 4;
  logic clk = 0, srst = 1, pfail = 0, msync = 0, ssync = 0, word = 0, lsb = 0;
  logic [8:0] cause = 9'h000;
  logic [3:0] lat = 4'h0;
  logic req, wr, ack, abort, tflag, load, pfw, busy;
  logic [15:0] addr, wdat, rdat, npc, npsw, nsp;
  logic [15:0] wa [2];
  logic [15:0] wd [2];
  logic [15:0] vecs [9] = '{`PTS_VEC_RESERVED, `PTS_VEC_BUS_ERR, `PTS_VEC_PARITY, `PTS_VEC_MMU,
    `PTS_VEC_FPU, `PTS_VEC_TRACE, `PTS_VEC_IOT, `PTS_VEC_EMT, `PTS_VEC_TRAP};
  int errors = 0, checks_done = 0, wn = 0, i;
  bit seen;
  pts_trap_sequencer #(.PF_RUN_CYC(40), .TIMEOUT_CYC(TO)) uut (.clk(clk), .srst(srst),
    .power_fail(pfail), .bus_master_sync(msync), .bus_slave_sync(ssync),
    .bus_word_access(word), .bus_addr_lsb(lsb), .reserved_instr(cause[0]),
    .stack_error(cause[1]), .parity_error(cause[2]), .mmu_violation(cause[3]),
    .fpu_exception(cause[4]), .trace_bit(cause[5]), .io_service_trap_instruction(cause[6]),
    .emulator_trap_instruction(cause[7]), .trap_instruction(cause[8]), .cur_pc(16'h1234),
    .cur_processor_status_word(16'h00E0), .cur_sp(16'h0F80), .mem_rdata(rdat),
    .mem_ack(ack), .mem_req(req), .mem_write(wr), .mem_addr(addr), .mem_wdata(wdat),
    .abort_instr(abort), .timeout_flag(tflag), .trap_busy(busy), .load_state(load),
    .new_pc(npc), .new_processor_status_word(npsw), .new_sp(nsp), .pf_window(pfw));
  pts_mem_model mem (.clk(clk), .mem_req(req), .mem_addr(addr), .lat(lat), .mem_ack(ack),
    .mem_rdata(rdat));
  initial forever #50 clk = ~clk;
  always @(posedge clk) if (req && ack && wr && wn < 2) begin
    wa[wn] <= addr;
    wd[wn] <= wdat;
    wn <= wn + 1;
  end
  task automatic close_out();
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic expect_trap(input logic [15:0] vec);
    bit bz;
    bz = 1'b0;
    for (i = 0; i < 200 && load !== 1'b1; i++) begin
      @(negedge clk);
      bz |= (busy === 1'b1);
    end
    chk("load_state", 16'h0001, {15'h0000, load});
    chk("trap_busy", 16'h0001, {15'h0000, bz});
    chk("busy_at_load", 16'h0000, {15'h0000, busy});
    chk("pushes", 16'h0002, 16'(wn));
    chk("new_pc", vec ^ 16'h3C00, npc);
    chk("new_psw", (vec + 16'h0002) ^ 16'h3C00, npsw);
    chk("new_sp", 16'h0F7C, nsp);
    chk("push1_addr", 16'h0F7E, wa[0]);
    chk("push1_data", 16'h00E0, wd[0]);
    chk("push2_addr", 16'h0F7C, wa[1]);
    chk("push2_data", 16'h1234, wd[1]);
    wn = 0;
    @(negedge clk);
  endtask
  task automatic t_causes();
    for (int k = 0; k < 9; k++) begin
      lat = 4'(k % 3);
      cause[k] = 1'b1;
      @(negedge clk);
      cause[k] = 1'b0;
      expect_trap(vecs[k]);
    end
  endtask
  task automatic t_priority();
    cause = 9'h101;
    @(negedge clk);
    cause = 9'h000;
    expect_trap(vecs[0]);
    expect_trap(vecs[8]);
  endtask
  task automatic t_bus(input bit odd);
    // odd: word access on odd byte; else: a slave that never answers
    {msync, word, lsb} = {1'b1, 1'b1, odd};
    seen = 0;
    for (i = 0; i < TO + 4 && !seen; i++) begin
      @(negedge clk);
      seen = (abort === 1'b1);
      if (!odd && tflag === 1'b1) chk("tflag_time", 16'(TO - 1), 16'(i));
    end
    msync = 1'b0;
    chk("abort", 16'h0001, 16'(seen));
    chk("tflag", 16'(!odd), {15'h0000, tflag});
    expect_trap(`PTS_VEC_BUS_ERR);
  endtask
  task automatic t_reply();
    // the reply lands two cycles short of the limit, then master sync stays up
    {msync, word, lsb, ssync} = 4'b1100;
    repeat (TO - 2) @(negedge clk);
    ssync = 1'b1;
    seen = 0;
    repeat (TO + 4) begin
      @(negedge clk);
      seen |= (tflag === 1'b1 || abort === 1'b1);
    end
    {msync, ssync} = 2'b00;
    chk("no_timeout", 16'h0000, 16'(seen));
  endtask
  task automatic t_power();
    pfail = 1'b1;
    expect_trap(`PTS_VEC_POWER);
    chk("pf_window", 16'h0001, {15'h0000, pfw});
    pfail = 1'b0;
    expect_trap(`PTS_VEC_POWER);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    t_causes();
    t_priority();
    t_reply();
    t_bus(1'b1);
    t_bus(1'b0);
    t_power();
    close_out();
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
